// ---- cppm_consts.vh ----
// constants for the configurable port pin block
`ifndef CPPM_CONSTS_VH
`define CPPM_CONSTS_VH

`define CPPM_NPINS        15
`define CPPM_MSB          14

`define CPPM_ADR_W        8
`define CPPM_ADR_LATCH    8'h00
`define CPPM_ADR_MODE_LO  8'h04
`define CPPM_ADR_MODE_HI  8'h08
`define CPPM_ADR_PIN      8'h0C
`define CPPM_ADR_CTRL     8'h10

`define CPPM_RST_LATCH    15'h7FFF
`define CPPM_RST_MODE_LO  15'h7FFF
`define CPPM_RST_MODE_HI  15'h0000
`define CPPM_RST_CTRL     1'h0

`define CPPM_MODE_QUASI   2'h0
`define CPPM_MODE_PUSH    2'h2
`define CPPM_MODE_INPUT   2'h1
`define CPPM_MODE_ODRAIN  2'h3

`define CPPM_WAKE_A       10
`define CPPM_WAKE_B       11

`define CPPM_LANE0_HI     7
`define CPPM_LANE1_LO     8
`define CPPM_CTRL_PD_BIT  0

`define CPPM_ZERO32       32'h0000_0000
`define CPPM_ZERO17       17'h0_0000
`define CPPM_ZERO31       31'h0000_0000

`endif

// ---- cppm_sync.v ----
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
`include "cppm_consts.vh"

module cppm_sync (
    input  wire                     clk_i,
    input  wire                     rst_i,
    input  wire [`CPPM_MSB:0]       async_i,
    output reg  [`CPPM_MSB:0]       stable_o
);

    reg [`CPPM_MSB:0] s1_reg;
    reg [`CPPM_MSB:0] s2_reg;
    reg [`CPPM_MSB:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < `CPPM_NPINS; i = i + 1) begin : g_bit
            always @(posedge clk_i) begin
                if (rst_i) begin
                    s1_reg[i]   <= 1'b0;
                    s2_reg[i]   <= 1'b0;
                    s3_reg[i]   <= 1'b0;
                    stable_o[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= async_i[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        stable_o[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// ---- cppm_port.v ----
// port pin mode logic with classic wishbone register access
//
// Summary of operation
// - each of fifteen pins has its own pair of mode select bits
// - mode low,high: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain
// - after reset all pins are input-only with drivers off
// - every pin input passes a schmitt stage in any mode
// - power-down disables inputs except port 3 bits 2 and 3
// - quasi pin is input and output at once, high weakly driven after a one-cycle strong pull-up
// - quasi pin drives strong low while its latch bit is zero
// - quasi pin has three separately controlled pull-ups
// - quasi very weak pull-up enabled while latch bit is one
// - quasi weak pull-up enabled while latch and sensed pin are both one
// - quasi strong pull-up enabled for one cycle when latch rises zero to one
// - open-drain keeps pull-ups off, pulls low while latch is zero
// - push-pull drives strong high for a one, same pull-down for a zero
`timescale 1ns/100ps
`include "cppm_consts.vh"

module cppm_port (
    input  wire                     clk_i,
    input  wire                     rst_i,
    input  wire                     cyc_i,
    input  wire                     stb_i,
    input  wire                     we_i,
    input  wire [`CPPM_ADR_W-1:0]   adr_i,
    input  wire [3:0]               sel_i,
    input  wire [31:0]              dat_i,
    output reg  [31:0]              dat_o,
    output reg                      ack_o,
    input  wire [`CPPM_MSB:0]       pad_in_i,
    output reg  [`CPPM_MSB:0]       pad_dout_o,
    output reg  [`CPPM_MSB:0]       pad_oe_n_o,
    output reg  [`CPPM_MSB:0]       weak_pu_o,
    output reg  [`CPPM_MSB:0]       vweak_pu_o,
    output reg  [`CPPM_MSB:0]       schmitt_en_o,
    output reg  [`CPPM_MSB:0]       pin_value_o,
    output reg                      pwr_down_o
);

    reg  [`CPPM_MSB:0]  port_output_latch_reg;
    reg  [`CPPM_MSB:0]  latch_prev_reg;
    reg  [`CPPM_MSB:0]  pin_mode_select_low_reg;
    reg  [`CPPM_MSB:0]  pin_mode_select_high_reg;
    reg                 pwr_down_reg;

    reg  [`CPPM_MSB:0]  latch_next;
    reg  [`CPPM_MSB:0]  mode_lo_next;
    reg  [`CPPM_MSB:0]  mode_hi_next;
    reg                 pwr_down_next;
    reg  [31:0]         rdata_next;

    wire [`CPPM_MSB:0]  pin_sync;
    wire [`CPPM_MSB:0]  schmitt_next;
    wire [`CPPM_MSB:0]  pin_gated;
    wire [`CPPM_MSB:0]  pull_down_next;
    wire [`CPPM_MSB:0]  strong_pu_next;
    wire [`CPPM_MSB:0]  weak_pu_next;
    wire [`CPPM_MSB:0]  vweak_pu_next;

    wire                bus_req;
    wire                bus_wr;
    wire                hit_latch;
    wire                hit_mode_lo;
    wire                hit_mode_hi;
    wire                hit_pin;
    wire                hit_ctrl;

    // pin resynchronisation
    // pin resync stage
    cppm_sync u_sync (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .async_i    (pad_in_i),
        .stable_o   (pin_sync)
    );

    // bus decode
    assign bus_req     = cyc_i & stb_i & ~ack_o;
    assign bus_wr      = bus_req & we_i;
    assign hit_latch   = (adr_i == `CPPM_ADR_LATCH);
    assign hit_mode_lo = (adr_i == `CPPM_ADR_MODE_LO);
    assign hit_mode_hi = (adr_i == `CPPM_ADR_MODE_HI);
    assign hit_pin     = (adr_i == `CPPM_ADR_PIN);
    assign hit_ctrl    = (adr_i == `CPPM_ADR_CTRL);

    // register write path with byte lanes
    // per pin mode bits
    always @* begin
        latch_next    = port_output_latch_reg;
        mode_lo_next  = pin_mode_select_low_reg;
        mode_hi_next  = pin_mode_select_high_reg;
        pwr_down_next = pwr_down_reg;
        if (bus_wr && hit_latch) begin
            if (sel_i[0]) begin
                latch_next[`CPPM_LANE0_HI:0] = dat_i[`CPPM_LANE0_HI:0];
            end
            if (sel_i[1]) begin
                latch_next[`CPPM_MSB:`CPPM_LANE1_LO] = dat_i[`CPPM_MSB:`CPPM_LANE1_LO];
            end
        end
        if (bus_wr && hit_mode_lo) begin
            if (sel_i[0]) begin
                mode_lo_next[`CPPM_LANE0_HI:0] = dat_i[`CPPM_LANE0_HI:0];
            end
            if (sel_i[1]) begin
                mode_lo_next[`CPPM_MSB:`CPPM_LANE1_LO] = dat_i[`CPPM_MSB:`CPPM_LANE1_LO];
            end
        end
        if (bus_wr && hit_mode_hi) begin
            if (sel_i[0]) begin
                mode_hi_next[`CPPM_LANE0_HI:0] = dat_i[`CPPM_LANE0_HI:0];
            end
            if (sel_i[1]) begin
                mode_hi_next[`CPPM_MSB:`CPPM_LANE1_LO] = dat_i[`CPPM_MSB:`CPPM_LANE1_LO];
            end
        end
        if (bus_wr && hit_ctrl && sel_i[0]) begin
            pwr_down_next = dat_i[`CPPM_CTRL_PD_BIT];
        end
    end

    // read data mux, unmapped reads zero
    always @* begin
        rdata_next = `CPPM_ZERO32;
        if (hit_latch) begin
            rdata_next = {`CPPM_ZERO17, port_output_latch_reg};
        end else if (hit_mode_lo) begin
            rdata_next = {`CPPM_ZERO17, pin_mode_select_low_reg};
        end else if (hit_mode_hi) begin
            rdata_next = {`CPPM_ZERO17, pin_mode_select_high_reg};
        end else if (hit_pin) begin
            rdata_next = {`CPPM_ZERO17, pin_value_o};
        end else if (hit_ctrl) begin
            rdata_next = {`CPPM_ZERO31, pwr_down_reg};
        end
    end

    // control registers
    // input-only reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_output_latch_reg    <= `CPPM_RST_LATCH;
            latch_prev_reg           <= `CPPM_RST_LATCH;
            pin_mode_select_low_reg  <= `CPPM_RST_MODE_LO;
            pin_mode_select_high_reg <= `CPPM_RST_MODE_HI;
            pwr_down_reg             <= `CPPM_RST_CTRL;
        end else begin
            port_output_latch_reg    <= latch_next;
            latch_prev_reg           <= port_output_latch_reg;
            pin_mode_select_low_reg  <= mode_lo_next;
            pin_mode_select_high_reg <= mode_hi_next;
            pwr_down_reg             <= pwr_down_next;
        end
    end

    // bus answer, one wait state
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `CPPM_ZERO32;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i) begin
                dat_o <= rdata_next;
            end
        end
    end

    // per pin driver decode
    genvar i;
    generate
        for (i = 0; i < `CPPM_NPINS; i = i + 1) begin : g_pin
            wire [1:0] mode;
            reg        pd_b;
            reg        spu_b;
            reg        wpu_b;
            reg        vwpu_b;

            assign mode = {pin_mode_select_high_reg[i], pin_mode_select_low_reg[i]};

            assign schmitt_next[i] = ~pwr_down_reg | (i == `CPPM_WAKE_A) | (i == `CPPM_WAKE_B);

            assign pin_gated[i] = pin_sync[i] & schmitt_next[i];

            always @* begin
                pd_b   = 1'b0;
                spu_b  = 1'b0;
                wpu_b  = 1'b0;
                vwpu_b = 1'b0;
                case (mode)
                    `CPPM_MODE_QUASI: begin
                        pd_b   = ~port_output_latch_reg[i];
                        vwpu_b = port_output_latch_reg[i];
                        wpu_b  = port_output_latch_reg[i] & pin_gated[i];
                        spu_b  = port_output_latch_reg[i] & ~latch_prev_reg[i];
                    end
                    `CPPM_MODE_PUSH: begin
                        pd_b  = ~port_output_latch_reg[i];
                        spu_b = port_output_latch_reg[i];
                    end
                    `CPPM_MODE_ODRAIN: begin
                        pd_b = ~port_output_latch_reg[i];
                    end
                    `CPPM_MODE_INPUT: begin
                        pd_b = 1'b0;
                    end
                    default: begin
                        pd_b = 1'b0;
                    end
                endcase
            end

            assign pull_down_next[i] = pd_b;
            assign strong_pu_next[i] = spu_b;
            assign weak_pu_next[i]   = wpu_b;
            assign vweak_pu_next[i]  = vwpu_b;
        end
    endgenerate

    // registered pin outputs
    // weak high drive
    always @(posedge clk_i) begin
        if (rst_i) begin
            pad_dout_o   <= {`CPPM_NPINS{1'b0}};
            pad_oe_n_o   <= {`CPPM_NPINS{1'b1}};
            weak_pu_o    <= {`CPPM_NPINS{1'b0}};
            vweak_pu_o   <= {`CPPM_NPINS{1'b0}};
            schmitt_en_o <= {`CPPM_NPINS{1'b1}};
            pin_value_o  <= {`CPPM_NPINS{1'b0}};
            pwr_down_o   <= 1'b0;
        end else begin
            pad_dout_o   <= strong_pu_next;
            pad_oe_n_o   <= ~(strong_pu_next | pull_down_next);
            weak_pu_o    <= weak_pu_next;
            vweak_pu_o   <= vweak_pu_next;
            schmitt_en_o <= schmitt_next;
            pin_value_o  <= pin_gated;
            pwr_down_o   <= pwr_down_reg;
        end
    end

endmodule

// ---- cppm_checker.sv ----
// assertions for the port pin block outputs
`timescale 1ns/100ps
module cppm_checker (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        ack_o,
    input wire [14:0] pad_in_i,
    input wire [14:0] pad_dout_o,
    input wire [14:0] pad_oe_n_o,
    input wire [14:0] weak_pu_o,
    input wire [14:0] vweak_pu_o,
    input wire [14:0] schmitt_en_o,
    input wire [14:0] pin_value_o,
    input wire        pwr_down_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [14:0] hi_q = ~pad_oe_n_o & pad_dout_o & vweak_pu_o;
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_rst; $fell(rst_i) |-> &pad_oe_n_o && !weak_pu_o && !vweak_pu_o; endproperty
    a_rst: assert property (p_rst) else $error("drivers enabled after reset");
    property p_strong; (hi_q & $past(hi_q)) == 15'h0000; endproperty
    a_strong: assert property (p_strong) else $error("strong pull-up too long");
    property p_low; (vweak_pu_o & ~pad_oe_n_o & ~pad_dout_o) == 15'h0000; endproperty
    a_low: assert property (p_low) else $error("low drive with latch one");
    property p_weak; (weak_pu_o & ~vweak_pu_o) == 15'h0000; endproperty
    a_weak: assert property (p_weak) else $error("weak pull-up alone");
    property p_pd; pwr_down_o && $past(pwr_down_o) |-> schmitt_en_o == 15'h0C00; endproperty
    a_pd: assert property (p_pd) else $error("inputs enabled in power-down");
    property p_run; !pwr_down_o && !$past(pwr_down_o) |-> &schmitt_en_o; endproperty
    a_run: assert property (p_run) else $error("input stage off");
    property p_gate; pwr_down_o [*8] |-> (pin_value_o & 15'h73FF) == 15'h0000; endproperty
    a_gate: assert property (p_gate) else $error("gated pin not zero");
    property p_sync; (!pwr_down_o && $stable(pad_in_i)) [*8] |-> pin_value_o == pad_in_i; endproperty
    a_sync: assert property (p_sync) else $error("pin value not followed");
    c_strong: cover property (|hi_q);
    c_weak: cover property (|weak_pu_o);
    c_pd: cover property (pwr_down_o [*8]);
endmodule

bind cppm_port cppm_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .pad_in_i(pad_in_i), .pad_dout_o(pad_dout_o), .pad_oe_n_o(pad_oe_n_o),
    .weak_pu_o(weak_pu_o), .vweak_pu_o(vweak_pu_o), .schmitt_en_o(schmitt_en_o),
    .pin_value_o(pin_value_o), .pwr_down_o(pwr_down_o));

// ---- cppm_pads.sv ----
// model of outside devices and pull-ups at the pins
`timescale 1ns/100ps
module cppm_pads (
    input  wire         clk_i,
    input  wire  [14:0] dout_i,
    input  wire  [14:0] oe_n_i,
    input  wire  [14:0] pu_i,
    input  wire  [14:0] ext_en_i,
    input  wire  [14:0] ext_val_i,
    output logic [14:0] pad_o = 15'h0000
);
    // strong drive wins, then outside device, then pull-up; a floating pin toggles
    always @(posedge clk_i) begin
        pad_o <= (~oe_n_i & dout_i) | (oe_n_i & ext_en_i & ext_val_i) | (oe_n_i & ~ext_en_i & (pu_i | ~pad_o));
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the port pin block
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [14:0] ext_en = 15'h7FFF;
    logic [14:0] ext_val = 15'h0000;
    logic [14:0] lo, hi, lat, rd;
    logic [89:0] e;
    wire  [31:0] dat;
    wire  [14:0] pad, dout, oe_n, wpu, vwpu, sch, pv;
    wire         ack, pd;
    int          err_total = 0;
    int          checks = 0;
    int          n;
    cppm_port dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wd), .dat_o(dat), .ack_o(ack), .pad_in_i(pad), .pad_dout_o(dout),
        .pad_oe_n_o(oe_n), .weak_pu_o(wpu), .vweak_pu_o(vwpu), .schmitt_en_o(sch),
        .pin_value_o(pv), .pwr_down_o(pd));
    cppm_pads u_pads (.clk_i(clk), .dout_i(dout), .oe_n_i(oe_n), .pu_i(wpu | vwpu),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad));
    always #10 clk = ~clk;
    task finish_test;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [14:0] g, input logic [14:0] x);
        checks++;
        if (g !== x) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [14:0] d, input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wd <= {17'h0_0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat[14:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // expected oe_n, dout, very weak, weak, pin level and defined mask
    function automatic logic [89:0] f_pins(input logic [14:0] ml, mh, l, ee, ev);
        logic [14:0] q, drv, dv, vw, lv;
        q = ~ml & ~mh;
        drv = ((q | (ml & mh)) & ~l) | (~ml & mh);
        dv = ~ml & mh & l;
        vw = q & l;
        lv = (drv & dv) | (~drv & ee & ev) | (~drv & ~ee & vw);
        return {~drv, dv, vw, vw & lv, lv, drv | ee | vw};
    endfunction
    initial begin
        void'($urandom(32'h201B3C5D));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(oe_n, 15'h7FFF);
        chk(dout | wpu | vwpu, 15'h0000);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, 8'(i * 4), 15'h0000, 4'hF);
            chk(rd, i < 2 ? 15'h7FFF : 15'h0000);
        end
        for (int k = 0; k < 12; k++) begin
            lo = k < 4 ? {15{k[0]}} : 15'($urandom);
            hi = k < 4 ? {15{k[1]}} : 15'($urandom);
            lat = 15'($urandom);
            ext_en <= 15'($urandom);
            ext_val <= 15'($urandom);
            wb(1'b1, 8'h00, lat, 4'hF);
            wb(1'b1, 8'h04, lo, 4'hF);
            wb(1'b1, 8'h08, hi, 4'hF);
            repeat (12) @(posedge clk);
            e = f_pins(lo, hi, lat, ext_en, ext_val);
            chk(oe_n, e[89:75]);
            chk(dout, e[74:60]);
            chk(vwpu, e[59:45]);
            chk(wpu, e[44:30]);
            chk(pv & e[14:0], e[29:15] & e[14:0]);
            wb(1'b0, 8'h00, 15'h0000, 4'hF);
            chk(rd, lat);
        end
        wb(1'b1, 8'h04, 15'h0000, 4'hF);
        wb(1'b1, 8'h08, 15'h0000, 4'hF);
        wb(1'b1, 8'h00, 15'h0000, 4'hF);
        wb(1'b1, 8'h00, 15'h7FFF, 4'hF);
        n = 0;
        repeat (6) begin
            if ((~oe_n & dout) === 15'h7FFF) n++;
            @(posedge clk);
        end
        chk(15'(n), 15'h0001);
        wb(1'b1, 8'h00, 15'h0000, 4'h1);
        wb(1'b0, 8'h00, 15'h0000, 4'hF);
        chk(rd, 15'h7F00);
        wb(1'b1, 8'h04, 15'h7FFF, 4'hF);
        ext_en <= 15'h7FFF;
        ext_val <= 15'h7FFF;
        wb(1'b1, 8'h10, 15'h0001, 4'h1);
        repeat (12) @(posedge clk);
        chk(sch, 15'h0C00);
        chk(pv, 15'h0C00);
        chk(15'(pd), 15'h0001);
        wb(1'b0, 8'h0C, 15'h0000, 4'hF);
        chk(rd, 15'h0C00);
        wb(1'b1, 8'h10, 15'h0000, 4'h1);
        repeat (12) @(posedge clk);
        chk(sch, 15'h7FFF);
        chk(pv, 15'h7FFF);
        chk(15'(pd), 15'h0000);
        finish_test;
    end
    initial begin
        #200000;
        err_total++;
        finish_test;
    end
endmodule
